// ---- cfs_pkg.sv ----
// package: constants and types for the converter fault supervisor
package cfs_pkg;
	// ----------------------------------------
	// timebase
	// ----------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
	// ----------------------------------------
	// times, in microseconds, and the overcurrent trip count
	// ----------------------------------------
	localparam int OC_WINDOW_US = 10;
	localparam int OC_INTERVAL_US = 50000;
	localparam int OC_LONG_DEB_US = 1300000;
	localparam int OC_SHORT_DEB_US = 150000;
	localparam int QUAL_FAST_US = 10;
	localparam int QUAL_SLOW_US = 100;
	localparam int QUAL_UV_US = 1000;
	localparam logic [2:0] OC_TRIP_LIMIT = 3'h7;
	// ----------------------------------------
	// second control register bits
	// ----------------------------------------
	localparam int CTL2_GUARD_OFF_BIT = 1;
	localparam int CTL2_DEB_SEL_BIT = 12;
	localparam int CTL2_W = 16;
	// ----------------------------------------
	// trip inputs from comparators
	// ----------------------------------------
	typedef struct packed {
		logic overcurrent_trip;
		logic input_ov;
		logic sys_ov_rel;
		logic sys_ov_clear;
		logic sys_abs_ov;
		logic sys_abs_clear;
		logic sys_uv;
		logic adp_ov_rel;
		logic adp_ov_clear;
		logic adp_uv;
		logic temp_hot;
		logic temp_cool;
	} cfs_trips_t;
	// ----------------------------------------
	// fault flags
	// ----------------------------------------
	typedef struct packed {
		logic oc_shutdown;
		logic input_ov;
		logic sys_ov;
		logic sys_abs_ov;
		logic sys_uv;
		logic adp_ov;
		logic adp_uv;
		logic over_temp;
	} cfs_faults_t;
endpackage

// ---- cfs_qual.sv ----
// qualification timer: counts a held condition, restarts on dropout
`timescale 1ns/1ps
`default_nettype none
module cfs_qual #(
	parameter int TICKS = 10
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic tick,
	input wire logic cond,
	output logic done
);
	initial begin
		if (TICKS < 1) begin
			$error("cfs_qual: TICKS must be at least 1");
		end
	end
	localparam int CW = $clog2(TICKS + 2);
	localparam logic [CW-1:0] LIMIT = CW'(TICKS);
	logic [CW-1:0] cnt_q;
	wire at_limit = (cnt_q > LIMIT);
	// strictly longer than the time: one tick past the limit
	always_ff @(posedge mclk) begin
		if (srst || !cond) begin
			cnt_q <= '0;
		end else if (tick && !at_limit) begin
			cnt_q <= cnt_q + CW'(1);
		end
	end
	assign done = at_limit;
endmodule
`default_nettype wire

// ---- cfs_top.sv ----
// converter fault supervisor: trip qualification, shutdown and retry
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module cfs_top #(
	parameter int OC_INTERVAL_US = cfs_pkg::OC_INTERVAL_US,
	parameter int OC_LONG_DEB_US = cfs_pkg::OC_LONG_DEB_US,
	parameter int OC_SHORT_DEB_US = cfs_pkg::OC_SHORT_DEB_US
) (
	input wire logic mclk,
	input wire logic srst,
	input wire cfs_pkg::cfs_trips_t trips,
	input wire logic [cfs_pkg::CTL2_W-1:0] second_control_register,
	input wire logic forward_good_in,
	input wire logic reverse_good_in,
	output logic switch_enable,
	output logic restart_req,
	output logic forward_power_good,
	output logic reverse_power_good,
	output cfs_pkg::cfs_faults_t faults
);
	initial begin
		if (OC_INTERVAL_US < cfs_pkg::OC_WINDOW_US || OC_SHORT_DEB_US < 1 || OC_LONG_DEB_US < 1) begin
			$error("cfs_top: time parameters too small");
		end
	end
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam int NT = $bits(cfs_pkg::cfs_trips_t);
	logic [NT-1:0] sync1_q;
	logic [NT-1:0] sync2_q;
	always_ff @(posedge mclk) begin
		sync1_q <= srst ? '0 : trips;
		sync2_q <= srst ? '0 : sync1_q;
	end
	cfs_pkg::cfs_trips_t t;
	assign t = cfs_pkg::cfs_trips_t'(sync2_q);
	// ----------------------------------------
	// 1us timebase
	// ----------------------------------------
	localparam int TBW = $clog2(cfs_pkg::TICK_CYC);
	localparam logic [TBW-1:0] TB_LAST = TBW'(cfs_pkg::TICK_CYC - 1);
	logic [TBW-1:0] tb_q;
	wire tick = (tb_q == TB_LAST);
	always_ff @(posedge mclk) begin
		tb_q <= (srst || tick) ? '0 : tb_q + TBW'(1);
	end
	// ----------------------------------------
	// control bits
	// ----------------------------------------
	wire guard_off = second_control_register[cfs_pkg::CTL2_GUARD_OFF_BIT];
	wire deb_short = second_control_register[cfs_pkg::CTL2_DEB_SEL_BIT];
	// ----------------------------------------
	// overcurrent: windowed counting
	// ----------------------------------------
	localparam int WW = $clog2(cfs_pkg::OC_WINDOW_US + 1);
	localparam logic [WW-1:0] WIN_LAST = WW'(cfs_pkg::OC_WINDOW_US - 1);
	localparam int IW = $clog2(OC_INTERVAL_US + 1);
	localparam logic [IW-1:0] INT_LAST = IW'(OC_INTERVAL_US - 1);
	localparam int DW = $clog2(OC_LONG_DEB_US + OC_SHORT_DEB_US + 1);
	localparam logic [DW-1:0] DEB_LONG = DW'(OC_LONG_DEB_US);
	localparam logic [DW-1:0] DEB_SHORT = DW'(OC_SHORT_DEB_US);
	typedef enum logic [2:0] {
		CFS_OC_RUN = 3'h1,
		CFS_OC_DEB = 3'h2,
		CFS_OC_RESTART = 3'h4
	} cfs_oc_st_t;
	cfs_oc_st_t oc_q;
	cfs_oc_st_t oc_d;
	logic [WW-1:0] win_q;
	logic win_used_q;
	logic [IW-1:0] int_q;
	logic int_run_q;
	logic [2:0] cnt_q;
	logic [DW-1:0] deb_q;
	wire oc_active = !guard_off && (oc_q == CFS_OC_RUN);
	wire win_end = tick && (win_q == WIN_LAST);
	wire oc_count = oc_active && t.overcurrent_trip && !win_used_q;
	wire int_end = tick && (int_q == INT_LAST);
	wire [2:0] cnt_next = cnt_q + 3'h1;
	wire oc_trip_now = oc_count && (cnt_next == cfs_pkg::OC_TRIP_LIMIT);
	wire deb_done = tick && (deb_q == '0);
	always_comb begin
		oc_d = oc_q;
		unique case (oc_q)
			CFS_OC_RUN: begin
				if (oc_trip_now) begin
					oc_d = CFS_OC_DEB;
				end
			end
			CFS_OC_DEB: begin
				if (deb_done) begin
					oc_d = CFS_OC_RESTART;
				end
			end
			CFS_OC_RESTART: begin
				oc_d = CFS_OC_RUN;
			end
			default: begin
				oc_d = CFS_OC_RUN;
			end
		endcase
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			oc_q <= CFS_OC_RUN;
		end else begin
			oc_q <= oc_d;
		end
	end
	// window: at most one count per 10us window
	always_ff @(posedge mclk) begin
		if (srst) begin
			win_q <= '0;
			win_used_q <= 1'b0;
		end else begin
			win_q <= win_end ? '0 : (tick ? win_q + WW'(1) : win_q);
			win_used_q <= win_end ? 1'b0 : (win_used_q | oc_count);
		end
	end
	// interval opens at the first count and lasts 50ms
	always_ff @(posedge mclk) begin
		if (srst || !oc_active) begin
			int_q <= '0;
			int_run_q <= 1'b0;
			cnt_q <= 3'h0;
		end else if (int_run_q && int_end && !oc_count) begin
			int_q <= '0;
			int_run_q <= 1'b0;
			cnt_q <= 3'h0;
		end else begin
			if (oc_count) begin
				cnt_q <= cnt_next;
				int_run_q <= 1'b1;
			end
			if (int_run_q && tick) begin
				int_q <= int_end ? '0 : int_q + IW'(1);
			end
		end
	end
	// debounce length latched at the shutdown
	always_ff @(posedge mclk) begin
		if (srst) begin
			deb_q <= '0;
		end else if (oc_trip_now) begin
			deb_q <= deb_short ? DEB_SHORT : DEB_LONG;
		end else if (oc_q == CFS_OC_DEB && tick && deb_q != '0) begin
			deb_q <= deb_q - DW'(1);
		end
	end
	// ----------------------------------------
	// qualification timers
	// ----------------------------------------
	localparam int NQ = 12;
	localparam int QT [NQ] = '{
		cfs_pkg::QUAL_FAST_US, cfs_pkg::QUAL_SLOW_US,
		cfs_pkg::QUAL_SLOW_US, cfs_pkg::QUAL_SLOW_US,
		cfs_pkg::QUAL_FAST_US, cfs_pkg::QUAL_SLOW_US,
		cfs_pkg::QUAL_UV_US, cfs_pkg::QUAL_SLOW_US,
		cfs_pkg::QUAL_SLOW_US, cfs_pkg::QUAL_UV_US,
		cfs_pkg::QUAL_SLOW_US, 1
	};
	// set/clear conditions per fault, in timer order
	wire [NQ-1:0] qcond = {
		1'b0,
		t.temp_cool,
		t.adp_uv,
		t.adp_ov_clear,
		t.adp_ov_rel,
		t.sys_uv,
		t.sys_abs_clear,
		t.sys_abs_ov,
		t.sys_ov_clear,
		t.sys_ov_rel,
		!t.input_ov,
		t.input_ov
	};
	wire [NQ-1:0] qdone;
	genvar gi;
	generate
		for (gi = 0; gi < NQ; gi++) begin : g_qual
			cfs_qual #(.TICKS(QT[gi])) u_qual (
				.mclk(mclk),
				.srst(srst),
				.tick(tick),
				.cond(qcond[gi]),
				.done(qdone[gi])
			);
		end
	endgenerate
	// ----------------------------------------
	// fault flags
	// ----------------------------------------
	cfs_pkg::cfs_faults_t f_q;
	cfs_pkg::cfs_faults_t f_d;
	always_comb begin
		f_d = f_q;
		f_d.oc_shutdown = (oc_d != CFS_OC_RUN);
		if (qdone[0]) f_d.input_ov = 1'b1;
		else if (qdone[1]) f_d.input_ov = 1'b0;
		if (qdone[2]) f_d.sys_ov = 1'b1;
		else if (qdone[3]) f_d.sys_ov = 1'b0;
		if (qdone[4]) f_d.sys_abs_ov = 1'b1;
		else if (qdone[5]) f_d.sys_abs_ov = 1'b0;
		f_d.sys_uv = qdone[6];
		if (qdone[7]) f_d.adp_ov = 1'b1;
		else if (qdone[8]) f_d.adp_ov = 1'b0;
		f_d.adp_uv = qdone[9];
		if (t.temp_hot) f_d.over_temp = 1'b1;
		else if (qdone[10]) f_d.over_temp = 1'b0;
	end
	always_ff @(posedge mclk) begin
		f_q <= srst ? '0 : f_d;
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// system undervoltage restart: pulse on the qualifying edge of sys_uv (adp_uv gives no restart)
	logic uv_prev_q;
	wire uv_rise = (qdone[6] && !uv_prev_q);
	wire stop = f_d.oc_shutdown | f_d.input_ov | f_d.sys_ov | f_d.sys_abs_ov
		| f_d.adp_ov | f_d.adp_uv | f_d.over_temp;
	always_ff @(posedge mclk) begin
		if (srst) begin
			uv_prev_q <= 1'b0;
			switch_enable <= 1'b0;
			restart_req <= 1'b0;
			forward_power_good <= 1'b0;
			reverse_power_good <= 1'b0;
			faults <= '0;
		end else begin
			uv_prev_q <= qdone[6];
			switch_enable <= !stop;
			restart_req <= (oc_d == CFS_OC_RESTART) | uv_rise;
			forward_power_good <= forward_good_in && !f_d.sys_ov && !f_d.sys_uv;
			reverse_power_good <= reverse_good_in && !f_d.adp_ov && !f_d.adp_uv;
			faults <= f_d;
		end
	end
endmodule
`default_nettype wire

// ---- cfs_comp_model.sv ----
// partner: comparator bank model feeding the supervisor
`timescale 1ns/1ps
`default_nettype none
module cfs_comp_model (
	input wire logic mclk,
	input wire cfs_pkg::cfs_trips_t want,
	output var cfs_pkg::cfs_trips_t trips
);
	// combinational, like an analog bank; the cool flag never stands while hot does
	always_comb begin
		trips = want;
		trips.temp_cool = want.temp_cool & ~want.temp_hot;
	end
endmodule
`default_nettype wire

// ---- cfs_sva.sv ----
// checker: port properties of the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module cfs_sva (
	input wire logic mclk,
	input wire logic srst,
	input wire cfs_pkg::cfs_trips_t trips,
	input wire logic [cfs_pkg::CTL2_W-1:0] second_control_register,
	input wire logic switch_enable,
	input wire logic restart_req,
	input wire logic forward_power_good,
	input wire logic reverse_power_good,
	input wire cfs_pkg::cfs_faults_t faults
);
	// ----
	// held-condition counters, saturating
	// ----
	logic [15:0] iov_q;
	logic [15:0] cool_q;
	always_ff @(posedge mclk) begin
		iov_q <= (srst | ~trips.input_ov) ? 16'h0 : iov_q + {15'h0, ~&iov_q};
		cool_q <= (srst | ~trips.temp_cool) ? 16'h0 : cool_q + {15'h0, ~&cool_q};
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	property p_oc_stop; $rose(faults.oc_shutdown) |-> !switch_enable; endproperty
	a_oc_stop: assert property (p_oc_stop) else $error("oc stop");
	property p_oc_retry; $fell(faults.oc_shutdown) |-> $past(restart_req); endproperty
	a_oc_retry: assert property (p_oc_retry) else $error("oc retry");
	property p_pulse; restart_req |=> !restart_req; endproperty
	a_pulse: assert property (p_pulse) else $error("restart pulse");
	property p_guard; second_control_register[1] [*8] |-> !$rose(faults.oc_shutdown); endproperty
	a_guard: assert property (p_guard) else $error("guard off");
	property p_iov_qual; $rose(faults.input_ov) |-> iov_q >= 16'd1250; endproperty
	a_iov_qual: assert property (p_iov_qual) else $error("iov early");
	property p_iov_must; iov_q == 16'd1650 |-> faults.input_ov && !switch_enable; endproperty
	a_iov_must: assert property (p_iov_must) else $error("iov late");
	property p_sysov; $rose(faults.sys_ov) |-> !switch_enable ##[0:1] !forward_power_good; endproperty
	a_sysov: assert property (p_sysov) else $error("sys ov");
	property p_adpov; $rose(faults.adp_ov) |-> !switch_enable ##[0:1] !reverse_power_good; endproperty
	a_adpov: assert property (p_adpov) else $error("adp ov");
	property p_temp; trips.temp_hot [*4] |-> !switch_enable && faults.over_temp; endproperty
	a_temp: assert property (p_temp) else $error("hot");
	property p_cool; $fell(faults.over_temp) |-> cool_q >= 16'd12500; endproperty
	a_cool: assert property (p_cool) else $error("cool early");
	c_oc: cover property ($rose(faults.oc_shutdown));
	c_iov: cover property ($rose(faults.input_ov));
	c_cool: cover property ($fell(faults.over_temp));
endmodule
bind cfs_top cfs_sva i_cfs_sva (.mclk(mclk), .srst(srst), .trips(trips),
	.second_control_register(second_control_register), .switch_enable(switch_enable),
	.restart_req(restart_req), .forward_power_good(forward_power_good),
	.reverse_power_good(reverse_power_good), .faults(faults));
`default_nettype wire

// ---- cfs_top_tb.sv ----
// testbench: scenario tasks for the converter fault supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module cfs_top_tb;
	// short debounce and interval keep the run small
	localparam int IV = 200;
	localparam int LD = 40;
	localparam int SD = 20;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	cfs_pkg::cfs_trips_t want = 12'h149;
	cfs_pkg::cfs_trips_t trips;
	logic [15:0] ctl = 16'h0;
	logic se, rr, fpg, rpg;
	cfs_pkg::cfs_faults_t flt;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	initial forever #4 mclk = ~mclk;
	cfs_comp_model i_cfs_comp_model (.mclk(mclk), .want(want), .trips(trips));
	cfs_top #(.OC_INTERVAL_US(IV), .OC_LONG_DEB_US(LD), .OC_SHORT_DEB_US(SD)) i_cfs_top (
		.mclk(mclk), .srst(srst), .trips(trips), .second_control_register(ctl),
		.forward_good_in(1'b1), .reverse_good_in(1'b1), .switch_enable(se),
		.restart_req(rr), .forward_power_good(fpg), .reverse_power_good(rpg), .faults(flt));
	// ----
	// helpers
	// ----
	task automatic clk(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// bounded, so a stuck output still ends the wait
	task automatic wait_o(input bit pick, input logic v, output int n);
		n = 0;
		while ((pick ? rr : se) !== v && n < 40000) begin
			@(posedge mclk);
			#1;
			n++;
		end
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// two pulses two cycles apart: one window
	task automatic oc_group(input int gap_us);
		@(posedge mclk) want.overcurrent_trip <= 1'b1;
		@(posedge mclk) want.overcurrent_trip <= 1'b0;
		@(posedge mclk) want.overcurrent_trip <= 1'b1;
		@(posedge mclk) want.overcurrent_trip <= 1'b0;
		clk(gap_us * 125);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset;
		`CHK("rst_se", 1'b0, se)
		@(posedge mclk) srst <= 1'b0;
		clk(2);
		#1;
		`CHK("run_se", 1'b1, se)
		`CHK("fpg", 1'b1, fpg)
		`CHK("rpg", 1'b1, rpg)
		`CHK("flt", 8'h0, flt)
		$display("test reset done");
	endtask
	task automatic t_oc(input logic sel, input int deb);
		int n;
		@(posedge mclk) ctl[12] <= sel;
		repeat (6) oc_group(12);
		`CHK("se_6", 1'b1, se)
		oc_group(0);
		wait_o(1'b0, 1'b0, n);
		`CHK("stop", 1'b1, n < 12)
		`CHK("oc_flag", 1'b1, flt.oc_shutdown)
		wait_o(1'b1, 1'b1, n);
		`CHK("deb", 1'b1, n > deb * 125 - 200 && n < deb * 125 + 300)
		@(posedge mclk);
		#1;
		`CHK("se_back", 1'b1, se)
		$display("test oc done");
	endtask
	task automatic t_guard;
		@(posedge mclk) ctl[1] <= 1'b1;
		repeat (8) oc_group(11);
		`CHK("guard_se", 1'b1, se)
		`CHK("guard_flag", 1'b0, flt.oc_shutdown)
		@(posedge mclk) ctl[1] <= 1'b0;
		$display("test guard done");
	endtask
	// b trips, c clears (negative: none), q qualify time in us
	task automatic t_qual(input int b, input int c, input int q, input string nm);
		int n;
		if (q > 0) begin
			@(posedge mclk) want[b] <= 1'b1;
			clk(q * 125 - 250);
			want[b] <= 1'b0;
			clk(20);
			`CHK({nm, "_drop"}, 1'b1, se)
		end
		@(posedge mclk);
		want[b] <= 1'b1;
		if (c >= 0) want[c] <= 1'b0;
		wait_o(1'b0, 1'b0, n);
		`CHK(nm, 1'b1, n >= q * 125 && n < q * 125 + 300)
		`CHK({nm, "_fpg"}, nm != "sysov", fpg)
		`CHK({nm, "_rpg"}, nm != "adpov", rpg)
		@(posedge mclk);
		want[b] <= 1'b0;
		if (c >= 0) want[c] <= 1'b1;
		wait_o(1'b0, 1'b1, n);
		`CHK({nm, "_clr"}, 1'b1, n >= 12500 && n < 12800)
		$display("test %s done", nm);
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 150000) begin
			num_errors++;
			finish_test;
		end
	end
	initial begin
		clk(6);
		t_reset;
		t_oc(1'b1, SD);
		t_guard;
		t_oc(1'b0, LD);
		t_qual(10, -1, 10, "iov");
		t_qual(1, 0, 0, "temp");
		t_qual(9, 8, 100, "sysov");
		t_qual(4, 3, 100, "adpov");
		finish_test;
	end
endmodule
`default_nettype wire
